// ===== pkg/mss_pkg.sv
// =====================================================================
// Purpose: constants and types for the motor start sequencer
// Assumes: 10 MHz pclk, APB register access with 32-bit data
// Notes: register map, field positions, reset values and timing
// =====================================================================
package mss_pkg;

  // =====================================================================
  // register map (byte addresses)
  localparam logic [7:0] MSS_OFS_CTRL = 8'h00;
  localparam logic [7:0] MSS_OFS_THR = 8'h04;
  localparam logic [7:0] MSS_OFS_TIME = 8'h08;
  localparam logic [7:0] MSS_OFS_STATUS = 8'h0C;

  // control register bit positions
  localparam int MSS_C_RUN = 0;
  localparam int MSS_C_SDE = 1;   // speed_detect_enable
  localparam int MSS_C_RVS = 2;   // reverse_drive_enable
  localparam int MSS_C_SBE = 3;   // stationary_brake_enable
  localparam int MSS_C_RSY = 4;   // resync_enable
  localparam int MSS_C_CST = 5;   // coast_enable
  localparam int MSS_C_BRK = 6;   // brake_enable
  localparam int MSS_C_BES = 7;   // brake_end_select: 0 time, 1 current
  localparam int MSS_C_BSS = 8;   // brake_side_select: 0 low, 1 high
  localparam int MSS_C_DIR = 9;   // commanded direction
  localparam int MSS_CTRL_W = 10;

  // reset values
  localparam logic [MSS_CTRL_W-1:0] MSS_CTRL_RST = 10'h000;
  localparam logic [31:0] MSS_THR_RST = 32'h0000_0000;
  localparam logic [23:0] MSS_TIME_RST = 24'h00_0000;

  // status field positions
  localparam int MSS_S_GATE = 10;
  localparam int MSS_S_STEP = 16;

  // gate patterns and commutation step limits
  localparam logic [2:0] MSS_GATE_ALL = 3'h7;
  localparam logic [2:0] MSS_GATE_NONE = 3'h0;
  localparam logic [2:0] MSS_STEP_LAST = 3'h5;
  localparam logic [2:0] MSS_STEP_FIRST = 3'h0;

  // timing: duration fields count in units of one millisecond
  localparam int MSS_CLK_MHZ = 10;
  localparam int MSS_TICK_US = 1000;
  localparam int MSS_TICK_CYC = MSS_TICK_US * MSS_CLK_MHZ;

  // sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_POWER_ON = 10'b00_0000_0001,
    ST_DETECT = 10'b00_0000_0010,
    ST_STAT_BRAKE = 10'b00_0000_0100,
    ST_COAST = 10'b00_0000_1000,
    ST_BRAKE = 10'b00_0001_0000,
    ST_STARTUP = 10'b00_0010_0000,
    ST_OPEN_LOOP = 10'b00_0100_0000,
    ST_REV_CL = 10'b00_1000_0000,
    ST_REV_OL = 10'b01_0000_0000,
    ST_CLOSED = 10'b10_0000_0000
  } mss_state_t;

endpackage : mss_pkg

// ===== test/mss_motor_model.sv
// =====================================================================
// Purpose: motor, adc and start-up engine seen from the sequencer
// Assumes: answers come lat_v cycles after a request settles
// Notes: adc fields read inverted outside the valid pulse
// =====================================================================
module mss_motor_model (
  // clock
  input wire logic pclk,
  // requests from the sequencer
  input wire logic detect_req,
  input wire logic startup_req,
  // adc sample of the phase voltages
  output logic adc_valid,
  output logic [7:0] adc_bemf,
  output logic [7:0] adc_speed,
  output logic adc_dir,
  output logic [2:0] adc_pos,
  // running motor and start-up engine
  output logic [7:0] motor_speed,
  output logic [7:0] phase_current,
  output logic comm_event,
  output logic pwm_in,
  output logic startup_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bemf_v = 8'h00, spd_v = 8'h00, mspd_v = 8'h00, cur_v = 8'h00;
  logic dir_v = 1'b0, comm_v = 1'b0, pwm_v = 1'b1;
  logic [2:0] pos_v = 3'h0;
  logic [1:0] rq_q = 2'h0;
  int lat_v = 1;
  int cnt_r = 0;
  // restart the answer delay whenever the request changes
  always_ff @(posedge pclk) begin
    rq_q <= {detect_req, startup_req};
    if ({detect_req, startup_req} != rq_q) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // one-cycle answers, fields garbled when not valid
  assign adc_valid = detect_req && rq_q == 2'h2 && cnt_r == lat_v;
  assign startup_done = startup_req && rq_q == 2'h1 && cnt_r == lat_v;
  assign adc_bemf = adc_valid ? bemf_v : ~bemf_v;
  assign adc_speed = adc_valid ? spd_v : ~spd_v;
  assign adc_dir = adc_valid ? dir_v : ~dir_v;
  assign adc_pos = adc_valid ? pos_v : ~pos_v;
  // levels of the running motor
  assign motor_speed = mspd_v;
  assign phase_current = cur_v;
  assign comm_event = comm_v;
  assign pwm_in = pwm_v;
endmodule : mss_motor_model

// ===== test/mss_start_sequencer_tb_top.sv
// =====================================================================
// Purpose: self-checking bench of the start sequencer
// Assumes: tick shortened to 4 cycles, zero wait apb slave
// Notes: each scenario configures over apb and follows the states
// =====================================================================
module mss_start_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mss_pkg::*;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wake = 1'b0, dir_change = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, detect_req, adc_valid, adc_dir, startup_req, startup_done;
  logic comm_event, pwm_in;
  logic [7:0] adc_bemf, adc_speed, motor_speed, phase_current;
  logic [2:0] adc_pos, gate_hs, gate_ls;
  logic [9:0] seq_state;
  int err_count = 0, checked = 0;
  // design and partner
  mss_start_sequencer #(.TICK_CYCLES(4)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wake, .dir_change,
    .detect_req, .adc_valid, .adc_bemf, .adc_speed, .adc_dir, .adc_pos, .motor_speed,
    .phase_current, .comm_event, .pwm_in, .startup_req, .startup_done, .seq_state,
    .gate_hs, .gate_ls);
  mss_motor_model u_m (.pclk, .detect_req, .startup_req, .adc_valid, .adc_bemf,
    .adc_speed, .adc_dir, .adc_pos, .motor_speed, .phase_current, .comm_event,
    .pwm_in, .startup_done);
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #2_000_000;
    err_count++;
    print_verdict();
  end
  // comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // one apb transfer, result in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
    chk(e, 0);
  endtask : rd
  function automatic logic [31:0] b(input int i);
    return 32'h0000_0001 << i;
  endfunction : b
  // restart the sequence from power-on with a new control word
  task automatic cfg(input logic [31:0] c);
    apb(1'b1, MSS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, MSS_OFS_CTRL, c | b(MSS_C_RUN));
  endtask : cfg
  task automatic wst(input logic [9:0] s);
    int n;
    n = 0;
    while (seq_state !== s && n < 300) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(seq_state, s);
  endtask : wst
  task automatic gchk(input logic [2:0] hs, input logic [2:0] ls);
    chk(gate_hs, hs);
    chk(gate_ls, ls);
  endtask : gchk
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  // reset values, access kinds and an unmapped address
  task automatic t_regs();
    rd(MSS_OFS_CTRL, 32'h0000_0000);
    rd(MSS_OFS_THR, 32'h0000_0000);
    rd(MSS_OFS_TIME, 32'h0000_0000);
    chk(seq_state, ST_POWER_ON);
    apb(1'b1, MSS_OFS_THR, 32'h3020_4010);
    rd(MSS_OFS_THR, 32'h3020_4010);
    apb(1'b1, MSS_OFS_TIME, 32'h0001_0102);
    rd(MSS_OFS_TIME, 32'h0001_0102);
    apb(1'b1, MSS_OFS_STATUS, 32'hFFFF_FFFF);
    rd(MSS_OFS_STATUS, 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(e, 32'h0000_0001);
    chk(q, 32'h0000_0000);
  endtask : t_regs
  // forward spin above the resync level, then a wake
  task automatic t_resync();
    u_m.bemf_v <= 8'h80;
    u_m.pos_v <= 3'h3;
    u_m.lat_v <= 2;
    cfg(b(MSS_C_SDE) | b(MSS_C_RSY));
    wst(ST_DETECT);
    chk(detect_req, 1);
    wst(ST_CLOSED);
    gchk(3'b010, 3'b001);
    @(posedge pclk);
    u_m.comm_v <= 1'b1;
    @(posedge pclk);
    u_m.comm_v <= 1'b0;
    settle(3);
    gchk(3'b100, 3'b001);
    @(posedge pclk);
    u_m.pwm_v <= 1'b0;
    settle(3);
    gchk(3'b000, 3'b001);
    @(posedge pclk);
    u_m.pwm_v <= 1'b1;
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    #1;
    chk(seq_state, ST_POWER_ON);
    u_m.bemf_v <= 8'h40;
    cfg(b(MSS_C_SDE) | b(MSS_C_RSY));
    wst(ST_STARTUP);
  endtask : t_resync
  // stationary motor through the stationary brake
  task automatic t_stat();
    int n;
    n = 0;
    u_m.bemf_v <= 8'h05;
    cfg(b(MSS_C_SDE) | b(MSS_C_SBE));
    wst(ST_STAT_BRAKE);
    gchk(3'b000, 3'b111);
    while (seq_state === ST_STAT_BRAKE && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(n >= 8 && n <= 10, 1);
    wst(ST_STARTUP);
    chk(startup_req, 1);
    wst(ST_OPEN_LOOP);
    @(posedge pclk);
    u_m.mspd_v <= 8'h60;
    wst(ST_CLOSED);
  endtask : t_stat
  // forward spin without resync: coast then high-side brake
  task automatic t_coast();
    u_m.bemf_v <= 8'h80;
    u_m.mspd_v <= 8'h00;
    cfg(b(MSS_C_SDE) | b(MSS_C_CST) | b(MSS_C_BRK) | b(MSS_C_BSS));
    wst(ST_COAST);
    gchk(3'b000, 3'b000);
    wst(ST_BRAKE);
    gchk(3'b111, 3'b000);
    wst(ST_STARTUP);
  endtask : t_coast
  // reverse spin with and without reverse drive, then a direction change
  task automatic t_rev();
    u_m.dir_v <= 1'b1;
    u_m.spd_v <= 8'h80;
    u_m.mspd_v <= 8'h80;
    cfg(b(MSS_C_SDE) | b(MSS_C_RVS));
    wst(ST_REV_CL);
    settle(10);
    chk(seq_state, ST_REV_CL);
    u_m.mspd_v <= 8'h10;
    wst(ST_REV_OL);
    @(posedge pclk);
    u_m.mspd_v <= 8'h00;
    settle(3);
    u_m.mspd_v <= 8'h60;
    wst(ST_CLOSED);
    u_m.mspd_v <= 8'h00;
    cfg(b(MSS_C_SDE));
    wst(ST_STARTUP);
    u_m.dir_v <= 1'b0;
    dir_change <= 1'b1;
    cfg(b(MSS_C_SDE) | b(MSS_C_RVS));
    wst(ST_REV_CL);
    dir_change <= 1'b0;
  endtask : t_rev
  // detection off: current-ended low-side brake, slow start-up engine
  task automatic t_cur();
    u_m.cur_v <= 8'h50;
    u_m.mspd_v <= 8'h00;
    u_m.lat_v <= 20;
    cfg(b(MSS_C_BRK) | b(MSS_C_BES));
    wst(ST_BRAKE);
    gchk(3'b000, 3'b111);
    settle(20);
    chk(seq_state, ST_BRAKE);
    u_m.cur_v <= 8'h10;
    wst(ST_STARTUP);
    wst(ST_OPEN_LOOP);
  endtask : t_cur
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_resync();
    t_stat();
    t_coast();
    t_rev();
    t_cur();
    print_verdict();
  end
endmodule : mss_start_sequencer_tb_top

// ===== verilog/mss_start_sequencer.sv
// =====================================================================
// Purpose: start_sequence_fsm choosing how a sensorless motor is started
// Assumes: all inputs synchronous to pclk; adc samples phase voltages
// Notes: registers over APB, zero wait states; gates are registered
// =====================================================================
// How it works
// - enter power-on state at reset and on every standby or sleep exit
// - pending direction change makes detected spin count as reverse
// - from power-on go to speed detect if enabled, else brake check
// - back-EMF under stationary threshold goes to stationary brake check
// - stationary brake enable picks stationary brake, else start-up
// - stationary brake turns all low-side switches on for set time
// - forward spin goes to resync check, reverse spin to reverse check
// - resync enabled compares back-EMF, disabled goes to coast check
// - back-EMF over resync minimum seeds position and enters closed loop
// - reverse drive enabled judges reverse speed, else coast check
// - stay reverse closed loop above handoff speed, then open loop
// - open loop crosses zero, accelerates forward, then closed loop
// - coast enable runs coast, else goes to brake check
// - coast turns every switch off for the coast time
// - brake enable runs brake, else goes to motor start-up
// - brake ends on brake time or when current drops under limit
// - brake uses high or low side switches as selected
// - finished start-up method leads into open-loop acceleration
// - closed loop drives trapezoidal six-step commutation
// - initial speed, position and direction come from phase adc samples
module mss_start_sequencer #(
  parameter int TICK_CYCLES = mss_pkg::MSS_TICK_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power state and commands
  input wire logic wake,
  input wire logic dir_change,
  // initial speed detect sampling
  output logic detect_req,
  input wire logic adc_valid,
  input wire logic [7:0] adc_bemf,
  input wire logic [7:0] adc_speed,
  input wire logic adc_dir,
  input wire logic [2:0] adc_pos,
  // running motor feedback
  input wire logic [7:0] motor_speed,
  input wire logic [7:0] phase_current,
  input wire logic comm_event,
  input wire logic pwm_in,
  // start-up method engine
  output logic startup_req,
  input wire logic startup_done,
  // seq state and gates
  output logic [9:0] seq_state,
  output logic [2:0] gate_hs,
  output logic [2:0] gate_ls
);
  import mss_pkg::*;

  // =====================================================================
  // registers and state
  logic [MSS_CTRL_W-1:0] ctrl_r;
  logic [31:0] thr_r;
  logic [23:0] time_r;
  logic [31:0] prdata_r;
  mss_state_t state_r, state_nxt;
  logic dir_chg_r;
  logic crossed_r;
  logic [2:0] step_r;
  logic [2:0] gate_hs_r, gate_ls_r;
  logic [31:0] tick_cnt_r;
  logic [7:0] timer_r;
  logic tick;
  logic timer_done, seed_now;
  logic [5:0] drive_gates;
  logic reverse_spin;
  logic wr_en, rd_en, addr_ok;
  logic [7:0] stat_thr, resync_min, brake_lim, handoff;

  assign stat_thr = thr_r[7:0];
  assign resync_min = thr_r[15:8];
  assign brake_lim = thr_r[23:16];
  assign handoff = thr_r[31:24];

  // =====================================================================
  // decode helpers, used by bus logic and state decisions
  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a == MSS_OFS_CTRL) || (a == MSS_OFS_THR) ||
                 (a == MSS_OFS_TIME) || (a == MSS_OFS_STATUS);
  endfunction : addr_valid

  function automatic mss_state_t brake_check(input logic [MSS_CTRL_W-1:0] c);
    brake_check = c[MSS_C_BRK] ? ST_BRAKE : ST_STARTUP;
  endfunction : brake_check

  function automatic mss_state_t stat_check(input logic [MSS_CTRL_W-1:0] c);
    stat_check = c[MSS_C_SBE] ? ST_STAT_BRAKE : ST_STARTUP;
  endfunction : stat_check

  function automatic mss_state_t coast_check(input logic [MSS_CTRL_W-1:0] c);
    coast_check = c[MSS_C_CST] ? ST_COAST : brake_check(c);
  endfunction : coast_check

  // six-step table: {hs, ls} for each commutation step
  function automatic logic [5:0] trap_gates(input logic [2:0] s);
    case (s)
      3'h0: trap_gates = {3'b001, 3'b010};
      3'h1: trap_gates = {3'b001, 3'b100};
      3'h2: trap_gates = {3'b010, 3'b100};
      3'h3: trap_gates = {3'b010, 3'b001};
      3'h4: trap_gates = {3'b100, 3'b001};
      3'h5: trap_gates = {3'b100, 3'b010};
      default: trap_gates = {MSS_GATE_NONE, MSS_GATE_NONE};
    endcase
  endfunction : trap_gates

  // =====================================================================
  // apb slave, no wait states, error on unmapped address
  assign addr_ok = addr_valid(paddr);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= MSS_CTRL_RST;
      thr_r <= MSS_THR_RST;
      time_r <= MSS_TIME_RST;
    end else if (wr_en) begin
      case (paddr)
        MSS_OFS_CTRL: ctrl_r <= pwdata[MSS_CTRL_W-1:0];
        MSS_OFS_THR: thr_r <= pwdata;
        MSS_OFS_TIME: time_r <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        MSS_OFS_CTRL: prdata_r <= {22'h00_0000, ctrl_r};
        MSS_OFS_THR: prdata_r <= thr_r;
        MSS_OFS_TIME: prdata_r <= {8'h00, time_r};
        MSS_OFS_STATUS: prdata_r <= {13'h0000, step_r, gate_hs_r, gate_ls_r, state_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // =====================================================================
  // millisecond tick and routine timer
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick || state_nxt != state_r) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // load the duration of the routine being entered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= 8'h00;
    end else if (state_nxt != state_r) begin
      case (state_nxt)
        ST_STAT_BRAKE: timer_r <= time_r[7:0];
        ST_COAST: timer_r <= time_r[15:8];
        ST_BRAKE: timer_r <= time_r[23:16];
        default: timer_r <= 8'h00;
      endcase
    end else if (tick && timer_r != 8'h00) begin
      timer_r <= timer_r - 8'h01;
    end
  end

  assign timer_done = (timer_r == 8'h00);

  // =====================================================================
  // direction change held from sequence start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_chg_r <= 1'b0;
    end else if (state_r == ST_POWER_ON) begin
      dir_chg_r <= dir_change;
    end
  end

  // detected spin against command, forced reverse by a pending change
  assign reverse_spin = (adc_dir != ctrl_r[MSS_C_DIR]) || dir_chg_r;

  // zero-speed crossing flag for reverse open loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossed_r <= 1'b0;
    end else if (state_r != ST_REV_OL) begin
      crossed_r <= 1'b0;
    end else if (motor_speed == 8'h00) begin
      crossed_r <= 1'b1;
    end
  end

  // =====================================================================
  // next state decisions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWER_ON: if (ctrl_r[MSS_C_RUN]) begin
        state_nxt = ctrl_r[MSS_C_SDE] ? ST_DETECT : brake_check(ctrl_r);
      end
      ST_DETECT: begin
        if (adc_valid) begin
          if (adc_bemf < stat_thr) begin
            state_nxt = stat_check(ctrl_r);
          end else if (!reverse_spin) begin
            if (!ctrl_r[MSS_C_RSY]) begin
              state_nxt = coast_check(ctrl_r);
            end else if (adc_bemf > resync_min) begin
              state_nxt = ST_CLOSED;
            end else begin
              state_nxt = stat_check(ctrl_r);
            end
          end else if (ctrl_r[MSS_C_RVS]) begin
            state_nxt = (adc_speed > handoff) ? ST_REV_CL : ST_REV_OL;
          end else begin
            state_nxt = coast_check(ctrl_r);
          end
        end
      end
      ST_STAT_BRAKE: if (timer_done) state_nxt = ST_STARTUP;
      ST_COAST: if (timer_done) state_nxt = brake_check(ctrl_r);
      ST_BRAKE: if (ctrl_r[MSS_C_BES] ? (phase_current < brake_lim) : timer_done) begin
        state_nxt = ST_STARTUP;
      end
      ST_STARTUP: if (startup_done) state_nxt = ST_OPEN_LOOP;
      ST_OPEN_LOOP: if (motor_speed > handoff) state_nxt = ST_CLOSED;
      ST_REV_CL: if (!(motor_speed > handoff)) state_nxt = ST_REV_OL;
      ST_REV_OL: if (crossed_r && motor_speed > handoff) state_nxt = ST_CLOSED;
      ST_CLOSED: state_nxt = ST_CLOSED;
      default: state_nxt = ST_POWER_ON;
    endcase
    // leaving run or waking from standby restarts the sequence
    if (wake || !ctrl_r[MSS_C_RUN]) begin
      state_nxt = ST_POWER_ON;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_POWER_ON;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =====================================================================
  // resync seed; gates follow the seeded step from the first closed-loop cycle
  assign seed_now = (state_r == ST_DETECT) && (state_nxt == ST_CLOSED);
  assign drive_gates = trap_gates(seed_now ? adc_pos : step_r);

  // commutation step: seeded on resync, stepped on each commutation in drive states, backward while reversing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r <= MSS_STEP_FIRST;
    end else if (seed_now) begin
      step_r <= adc_pos;
    end else if (comm_event) begin
      if (state_r == ST_REV_CL || (state_r == ST_REV_OL && !crossed_r)) begin
        step_r <= (step_r == MSS_STEP_FIRST) ? MSS_STEP_LAST : step_r - 3'h1;
      end else if (state_r == ST_CLOSED || state_r == ST_OPEN_LOOP ||
                   state_r == ST_REV_OL) begin
        step_r <= (step_r == MSS_STEP_LAST) ? MSS_STEP_FIRST : step_r + 3'h1;
      end
    end
  end

  // gate drive, registered; pwm chops the high side while driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_hs_r <= MSS_GATE_NONE;
      gate_ls_r <= MSS_GATE_NONE;
    end else begin
      case (state_nxt)
        ST_STAT_BRAKE: begin
          gate_hs_r <= MSS_GATE_NONE;
          gate_ls_r <= MSS_GATE_ALL;
        end
        ST_BRAKE: begin
          gate_hs_r <= ctrl_r[MSS_C_BSS] ? MSS_GATE_ALL : MSS_GATE_NONE;
          gate_ls_r <= ctrl_r[MSS_C_BSS] ? MSS_GATE_NONE : MSS_GATE_ALL;
        end
        ST_CLOSED, ST_OPEN_LOOP, ST_REV_CL, ST_REV_OL: begin
          gate_hs_r <= pwm_in ? drive_gates[5:3] : MSS_GATE_NONE;
          gate_ls_r <= drive_gates[2:0];
        end
        default: begin
          gate_hs_r <= MSS_GATE_NONE;
          gate_ls_r <= MSS_GATE_NONE;
        end
      endcase
    end
  end

  assign gate_hs = gate_hs_r;
  assign gate_ls = gate_ls_r;
  assign seq_state = state_r;
  assign detect_req = (state_r == ST_DETECT);
  assign startup_req = (state_r == ST_STARTUP);

  // =====================================================================
  // checks
  sequence s_detect_resync;
    state_r == ST_DETECT && adc_valid && ctrl_r[MSS_C_RUN] && !wake &&
      !(adc_bemf < stat_thr) && !reverse_spin && ctrl_r[MSS_C_RSY] &&
      adc_bemf > resync_min;
  endsequence

  sequence s_closed_seeded(logic [2:0] p);
    state_r == ST_CLOSED && step_r == p;
  endsequence

  property p_wake_restart;
    @(posedge pclk) disable iff (!presetn) wake |=> state_r == ST_POWER_ON;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("no restart on wake");

  property p_skip_detect;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_POWER_ON && ctrl_r[MSS_C_RUN] && !ctrl_r[MSS_C_SDE] && !wake
      |=> state_r == ($past(ctrl_r[MSS_C_BRK]) ? ST_BRAKE : ST_STARTUP);
  endproperty
  a_skip_detect: assert property (p_skip_detect) else $error("bad skip of detect");

  property p_stationary;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_DETECT && adc_valid && adc_bemf < stat_thr && ctrl_r[MSS_C_RUN] && !wake
      |=> state_r == ($past(ctrl_r[MSS_C_SBE]) ? ST_STAT_BRAKE : ST_STARTUP);
  endproperty
  a_stationary: assert property (p_stationary) else $error("bad stationary branch");

  property p_stat_gates;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_STAT_BRAKE |-> gate_ls == MSS_GATE_ALL && gate_hs == MSS_GATE_NONE;
  endproperty
  a_stat_gates: assert property (p_stat_gates) else $error("stationary brake gates");

  property p_resync_seed;
    logic [2:0] p;
    @(posedge pclk) disable iff (!presetn)
      (s_detect_resync, p = adc_pos) |=> s_closed_seeded(p);
  endproperty
  a_resync_seed: assert property (p_resync_seed) else $error("resync not seeded");

  property p_rev_hold;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_REV_CL && motor_speed > handoff && ctrl_r[MSS_C_RUN] && !wake
      |=> state_r == ST_REV_CL;
  endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("left reverse closed loop");

  property p_coast_off;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_COAST |-> gate_hs == MSS_GATE_NONE && gate_ls == MSS_GATE_NONE;
  endproperty
  a_coast_off: assert property (p_coast_off) else $error("coast gates not off");

  property p_brake_side;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_BRAKE && $stable(ctrl_r) |->
        (ctrl_r[MSS_C_BSS] ? gate_hs : gate_ls) == MSS_GATE_ALL;
  endproperty
  a_brake_side: assert property (p_brake_side) else $error("brake side wrong");

  property p_startup_ol;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_STARTUP && startup_done && ctrl_r[MSS_C_RUN] && !wake
      |=> state_r == ST_OPEN_LOOP;
  endproperty
  a_startup_ol: assert property (p_startup_ol) else $error("no open loop after start");

endmodule : mss_start_sequencer
